// ---- rtl/dmag_map.svh ----
// Address map, field limits and reset values for the data memory address generator
`ifndef DMAG_MAP_SVH
`define DMAG_MAP_SVH
// Pointer registers in the special register space (12-bit data addresses)
`define DMAG_PTR0_LO 12'hfe9
`define DMAG_PTR0_HI 12'hfea
`define DMAG_PTR1_LO 12'hfe1
`define DMAG_PTR1_HI 12'hfe2
`define DMAG_PTR2_LO 12'hfd9
`define DMAG_PTR2_HI 12'hfda
// Virtual access register bases per pair, group from base up: plus-working, inc-before, dec-after, inc-after, plain
`define DMAG_VIRT0_BASE 12'hfeb
`define DMAG_VIRT1_BASE 12'hfe3
`define DMAG_VIRT2_BASE 12'hfdb
// Offset of each virtual register from its pair's base (base is plus-working, then up)
`define DMAG_OFS_POINTER_PLUS_WORKING_ACCESS 3'h0
`define DMAG_OFS_INCREMENT_THEN_ACCESS 3'h1
`define DMAG_OFS_ACCESS_THEN_DECREMENT 3'h2
`define DMAG_OFS_ACCESS_THEN_INCREMENT 3'h3
`define DMAG_OFS_INDF 3'h4
// Largest literal offset taken as an index, and the access bank split
`define DMAG_LIT_MAX 8'h5f
`define DMAG_ACC_HIGH_BASE 12'hf00
// Value returned by a refused indirect read
`define DMAG_NULL_BYTE 8'h00
// Pointer reset value
`define DMAG_PTR_RST 12'h000
`endif

// ---- rtl/dmag_pkg.sv ----
// Types shared by the data memory address generator
package dmag_pkg;
  // Kind of operand access asked by the core
  typedef enum logic [1:0] {
    DMAG_OP_NONE,
    DMAG_OP_DIRECT,
    DMAG_OP_LITERAL
  } dmag_op_t;
  // One operand request from the execution core
  typedef struct packed {
    logic valid;
    dmag_op_t op;
    logic wr;
    logic acc_b;
    logic [7:0] file;
    logic [3:0] bank;
    logic [7:0] wreg;
    logic [7:0] wdata;
  } dmag_req_t;
  // Resolved memory access toward data memory
  typedef struct packed {
    logic rd;
    logic wr;
    logic [11:0] addr;
    logic [7:0] wdata;
  } dmag_mem_t;
endpackage

// ---- rtl/dmag_core.sv ----
// Data memory address generator: pointer pairs, virtual access registers, literal-offset indexing
`timescale 1ns/100ps
`include "dmag_map.svh"
module dmag_core (
  input wire logic REF_CLK,
  input wire logic RST_B,
  input wire logic EXT_SET_EN,
  input dmag_pkg::dmag_req_t REQ,
  input wire logic [7:0] MEM_RDATA,
  output dmag_pkg::dmag_mem_t MEM,
  output logic [7:0] RDATA,
  output logic RVALID,
  output logic [11:0] PTR0,
  output logic [11:0] PTR1,
  output logic [11:0] PTR2
);
  import dmag_pkg::*;

  // Pointer pairs; the high nibble of the high byte is not implemented in 12-bit space
  logic [11:0] ptr_q [3];
  // Strap-like enable: three stage sync since it comes from configuration pins
  logic [2:0] ext_sync_q;
  logic ext_en_q;
  // Resolved access for this cycle
  logic [11:0] eff_addr;
  logic eff_rd, eff_wr, eff_null;
  logic [1:0] ind_sel;
  logic ind_hit;
  logic [2:0] ind_kind;
  logic [7:0] reg_rdata;
  logic reg_hit;
  // Registered outputs
  dmag_mem_t mem_q;
  logic [7:0] rdata_q;
  logic rvalid_q;
  logic pend_mem_q;

  // Base of the virtual group for pair n
  function automatic logic [11:0] virt_base(input logic [1:0] n);
    unique case (n)
      2'd0: virt_base = `DMAG_VIRT0_BASE;
      2'd1: virt_base = `DMAG_VIRT1_BASE;
      default: virt_base = `DMAG_VIRT2_BASE;
    endcase
  endfunction

  // True when an address is any of the fifteen virtual access registers
  function automatic logic is_virtual(input logic [11:0] a);
    logic hit;
    hit = 1'b0;
    for (int n = 0; n < 3; n++) begin
      if (a >= virt_base(n[1:0]) && a <= virt_base(n[1:0]) + 12'(`DMAG_OFS_INDF)) begin
        hit = 1'b1;
      end
    end
    is_virtual = hit;
  endfunction

  // Pointer plus signed-free 8-bit offset, wrapping inside the address space
  function automatic logic [11:0] ptr_add(input logic [11:0] p, input logic [7:0] ofs);
    ptr_add = 12'(p + {4'h0, ofs});
  endfunction

  // Configuration enable synchroniser; only stages two and three are compared
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ext_sync_q <= 3'h0;
      ext_en_q <= 1'b0;
    end else begin
      ext_sync_q <= {ext_sync_q[1:0], EXT_SET_EN};
      if (ext_sync_q[2] == ext_sync_q[1]) begin
        ext_en_q <= ext_sync_q[2];
      end
    end
  end

  // Address formation for a direct-class operand
  always_comb begin
    logic [11:0] dir_addr;
    dir_addr = 12'h000;
    if (REQ.acc_b) begin
      dir_addr = {REQ.bank, REQ.file};
    end else if (REQ.file >= 8'h80) begin
      dir_addr = `DMAG_ACC_HIGH_BASE | {4'h0, REQ.file};
    end else begin
      dir_addr = {4'h0, REQ.file};
    end
    // Literal offset mode, bank select ignored
    if (ext_en_q && !REQ.acc_b && REQ.file <= `DMAG_LIT_MAX) begin
      dir_addr = ptr_add(ptr_q[2], REQ.file);
    end
    // Inherent and literal kinds never get here
    eff_addr = (REQ.valid && REQ.op == DMAG_OP_DIRECT) ? dir_addr : 12'h000;
  end

  // Decode whether the formed address is a virtual register and which pair
  always_comb begin
    ind_hit = 1'b0;
    ind_sel = 2'd0;
    ind_kind = 3'h0;
    for (int n = 0; n < 3; n++) begin
      if (eff_addr >= virt_base(n[1:0]) && eff_addr <= virt_base(n[1:0]) + 12'(`DMAG_OFS_INDF)) begin
        ind_hit = 1'b1;
        ind_sel = n[1:0];
        ind_kind = 3'(eff_addr - virt_base(n[1:0]));
      end
    end
  end

  // Indirect target and whether it must be refused; pointers 0 and 1 act the same in either mode
  always_comb begin
    logic [11:0] p;
    logic [11:0] tgt;
    p = ptr_q[ind_sel];
    tgt = p;
    if (ind_kind == `DMAG_OFS_POINTER_PLUS_WORKING_ACCESS) begin
      tgt = ptr_add(p, REQ.wreg);
    end else if (ind_kind == `DMAG_OFS_INCREMENT_THEN_ACCESS) begin
      tgt = 12'(p + 12'h001);
    end
    eff_null = ind_hit && is_virtual(tgt);
    // Only direct-class operands reach data memory; the other kinds leave it alone
    eff_rd = REQ.valid && REQ.op == DMAG_OP_DIRECT && !REQ.wr;
    eff_wr = REQ.valid && REQ.op == DMAG_OP_DIRECT && REQ.wr;
  end

  // Pointer register reads for direct access
  always_comb begin
    reg_hit = 1'b1;
    unique case (eff_addr)
      `DMAG_PTR0_LO: reg_rdata = ptr_q[0][7:0];
      `DMAG_PTR0_HI: reg_rdata = {4'h0, ptr_q[0][11:8]};
      `DMAG_PTR1_LO: reg_rdata = ptr_q[1][7:0];
      `DMAG_PTR1_HI: reg_rdata = {4'h0, ptr_q[1][11:8]};
      `DMAG_PTR2_LO: reg_rdata = ptr_q[2][7:0];
      `DMAG_PTR2_HI: reg_rdata = {4'h0, ptr_q[2][11:8]};
      default: begin
        reg_hit = 1'b0;
        reg_rdata = 8'h00;
      end
    endcase
  end

  // Pointer update: direct writes, own-port loads and auto-modify; no status flags live here
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      for (int n = 0; n < 3; n++) begin
        ptr_q[n] <= `DMAG_PTR_RST;
      end
    end else if (eff_wr && reg_hit) begin
      // Direct write to a pointer byte
      unique case (eff_addr)
        `DMAG_PTR0_LO: ptr_q[0][7:0] <= REQ.wdata;
        `DMAG_PTR0_HI: ptr_q[0][11:8] <= REQ.wdata[3:0];
        `DMAG_PTR1_LO: ptr_q[1][7:0] <= REQ.wdata;
        `DMAG_PTR1_HI: ptr_q[1][11:8] <= REQ.wdata[3:0];
        `DMAG_PTR2_LO: ptr_q[2][7:0] <= REQ.wdata;
        default: ptr_q[2][11:8] <= REQ.wdata[3:0];
      endcase
    end else if (ind_hit && !eff_null && (eff_rd || eff_wr)) begin
      // Target is the own pair's register: the written byte lands there, no step
      if (eff_wr && is_ptr_of(ptr_target(), ind_sel)) begin
        if (ptr_target() == lo_addr(ind_sel)) begin
          ptr_q[ind_sel][7:0] <= REQ.wdata;
        end else begin
          ptr_q[ind_sel][11:8] <= REQ.wdata[3:0];
        end
      end else if (ind_kind == `DMAG_OFS_ACCESS_THEN_DECREMENT) begin
        ptr_q[ind_sel] <= 12'(ptr_q[ind_sel] - 12'h001);
      end else if (ind_kind == `DMAG_OFS_ACCESS_THEN_INCREMENT || ind_kind == `DMAG_OFS_INCREMENT_THEN_ACCESS) begin
        ptr_q[ind_sel] <= 12'(ptr_q[ind_sel] + 12'h001);
      end
    end
  end

  // Target address of the current indirect access
  function automatic logic [11:0] ptr_target();
    logic [11:0] p;
    p = ptr_q[ind_sel];
    if (ind_kind == `DMAG_OFS_POINTER_PLUS_WORKING_ACCESS) begin
      p = ptr_add(p, REQ.wreg);
    end else if (ind_kind == `DMAG_OFS_INCREMENT_THEN_ACCESS) begin
      p = 12'(p + 12'h001);
    end
    ptr_target = p;
  endfunction

  // Low byte address of pair n
  function automatic logic [11:0] lo_addr(input logic [1:0] n);
    unique case (n)
      2'd0: lo_addr = `DMAG_PTR0_LO;
      2'd1: lo_addr = `DMAG_PTR1_LO;
      default: lo_addr = `DMAG_PTR2_LO;
    endcase
  endfunction

  // True when address a is the low or the high byte of pair n
  function automatic logic is_ptr_of(input logic [11:0] a, input logic [1:0] n);
    is_ptr_of = (a == lo_addr(n)) || (a == 12'(lo_addr(n) + 12'h001));
  endfunction

  // Memory side request one cycle after the request; read data one cycle after that, or with the request for pointer bytes and refusals
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      mem_q <= '0;
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
      pend_mem_q <= 1'b0;
    end else begin
      mem_q.rd <= 1'b0;
      mem_q.wr <= 1'b0;
      rvalid_q <= 1'b0;
      pend_mem_q <= 1'b0;
      if (eff_rd) begin
        if (eff_null) begin
          rdata_q <= `DMAG_NULL_BYTE;
          rvalid_q <= 1'b1;
        end else if (!ind_hit && reg_hit) begin
          rdata_q <= reg_rdata;
          rvalid_q <= 1'b1;
        end else begin
          // Ordinary location, including other special registers
          mem_q.rd <= 1'b1;
          mem_q.addr <= ind_hit ? ptr_target() : eff_addr;
          pend_mem_q <= 1'b1;
        end
      end else if (eff_wr && !eff_null && !reg_hit) begin
        if (!(ind_hit && is_ptr_of(ptr_target(), ind_sel))) begin
          mem_q.wr <= 1'b1;
          mem_q.addr <= ind_hit ? ptr_target() : eff_addr;
          mem_q.wdata <= REQ.wdata;
        end
      end
      if (pend_mem_q) begin
        rdata_q <= MEM_RDATA;
        rvalid_q <= 1'b1;
      end
    end
  end

  assign MEM = mem_q;
  assign RDATA = rdata_q;
  assign RVALID = rvalid_q;
  assign PTR0 = ptr_q[0];
  assign PTR1 = ptr_q[1];
  assign PTR2 = ptr_q[2];

  // Checks kept next to the logic
  sequence s_null_rd;
    eff_rd && eff_null;
  endsequence

  AST_NULL_READ: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    s_null_rd |=> RVALID && RDATA == 8'h00 && !MEM.rd) else $error("refused read not zero");
  AST_NULL_WRITE: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    eff_wr && eff_null |=> !MEM.wr) else $error("refused write reached memory");
  AST_ACCESS_THEN_INCREMENT: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    eff_rd && ind_hit && !eff_null && ind_kind == 3'h3 |=> PTR0 + PTR1 + PTR2 ==
    12'($past(PTR0) + $past(PTR1) + $past(PTR2) + 12'h001)) else $error("post increment wrong");
  AST_ACCESS_THEN_DECREMENT: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    eff_rd && ind_hit && !eff_null && ind_kind == 3'h2 |=> PTR0 + PTR1 + PTR2 ==
    12'($past(PTR0) + $past(PTR1) + $past(PTR2) - 12'h001)) else $error("post decrement wrong");
  AST_LITERAL: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    eff_rd && ext_en_q && REQ.op == DMAG_OP_DIRECT && !REQ.acc_b && REQ.file <= 8'h5f && !ind_hit && !reg_hit
    |=> MEM.rd && MEM.addr == 12'($past(PTR2) + {4'h0, $past(REQ.file)})) else $error("indexed address wrong");
  AST_DIRECT: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    eff_rd && REQ.acc_b && !ind_hit && !reg_hit |=> MEM.rd && MEM.addr == {$past(REQ.bank), $past(REQ.file)})
    else $error("banked address wrong");
  AST_NO_EXT: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    eff_rd && !ext_en_q && !REQ.acc_b && REQ.file < 8'h80 && !ind_hit && !reg_hit
    |=> MEM.addr == {4'h0, $past(REQ.file)}) else $error("access bank address wrong");
  AST_POINTER_PLUS_WORKING_ACCESS: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    eff_rd && ind_hit && !eff_null && ind_kind == 3'h0 && !reg_hit
    |=> $stable(PTR0) && $stable(PTR1) && $stable(PTR2) && MEM.rd
    && MEM.addr == 12'($past(ptr_q[ind_sel]) + {4'h0, $past(REQ.wreg)}))
    else $error("plus working address wrong or pointer moved");
  AST_IDLE: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    REQ.valid && REQ.op == DMAG_OP_LITERAL
    |=> !MEM.rd && !MEM.wr && $stable(PTR0) && $stable(PTR1) && $stable(PTR2))
    else $error("literal op touched memory");
  // A pointer byte read directly answers from the pair itself when no memory read is pending, else with the pending memory data
  AST_PTR_READ: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    eff_rd && !pend_mem_q && eff_addr == `DMAG_PTR0_LO |=> RVALID && RDATA == $past(PTR0[7:0]) && !MEM.rd)
    else $error("pointer byte read wrong");
  // Store through the third pair's own port while it aims at its own low byte: byte lands, no step
  AST_OWN_LOAD: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    eff_wr && ind_hit && ind_sel == 2'd2 && (ind_kind == `DMAG_OFS_INDF || ind_kind == `DMAG_OFS_ACCESS_THEN_DECREMENT)
    && PTR2 == `DMAG_PTR2_LO |=> PTR2 == {$past(PTR2[11:8]), $past(REQ.wdata)} && !MEM.wr)
    else $error("own pair store stepped or leaked");
endmodule // dmag_core

// ---- sim/dmag_mem_model.sv ----
// Behavioural data memory answering the address generator's resolved accesses
`timescale 1ns/100ps
module dmag_mem_model (
  input wire logic ref_clk,
  input dmag_pkg::dmag_mem_t mem,
  output logic [7:0] mem_rdata,
  output logic [15:0] wr_count
);
  import dmag_pkg::*;
  // Whole 12-bit space, seeded with a pattern the bench can predict
  logic [7:0] store_q [4096];
  initial begin
    for (int i = 0; i < 4096; i++) begin
      store_q[i] = i[7:0] ^ 8'h5a;
    end
    wr_count = 16'h0000;
  end
  // Writes land on the edge that sees the strobe, and are counted
  always @(posedge ref_clk) begin
    if (mem.wr === 1'b1) begin
      store_q[mem.addr] <= mem.wdata;
      wr_count <= wr_count + 16'h0001;
    end
  end
  // The generator takes read data at the edge that ends the cycle in which rd stands, so the
  // answer is shown while rd is high; otherwise the inverse, so stale data never looks valid
  always_comb begin
    mem_rdata = (mem.rd === 1'b1) ? store_q[mem.addr] : ~store_q[mem.addr];
  end
endmodule // dmag_mem_model

// ---- sim/tb.sv ----
// Self-checking bench for the data memory address generator
`timescale 1ns/100ps
module tb;
  import dmag_pkg::*;
  logic REF_CLK, RST_B, EXT_SET_EN, RVALID;
  dmag_req_t REQ;
  dmag_mem_t MEM;
  logic [7:0] MEM_RDATA, RDATA, rd;
  logic [11:0] PTR0, PTR1, PTR2;
  logic [15:0] wr_count, n0;
  int bad_count, checks;
  dmag_core uut (.REF_CLK(REF_CLK), .RST_B(RST_B), .EXT_SET_EN(EXT_SET_EN), .REQ(REQ),
    .MEM_RDATA(MEM_RDATA), .MEM(MEM), .RDATA(RDATA), .RVALID(RVALID), .PTR0(PTR0), .PTR1(PTR1), .PTR2(PTR2));
  dmag_mem_model mem_u (.ref_clk(REF_CLK), .mem(MEM), .mem_rdata(MEM_RDATA), .wr_count(wr_count));
  // Seed pattern of the memory model
  function automatic logic [7:0] pat(input logic [11:0] a);
    return a[7:0] ^ 8'h5a;
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // One request held over its taking edge; reads wait a bounded time for the answer
  task automatic op(input dmag_op_t k, input logic w, input logic a, input logic [11:0] ad,
                    input logic [7:0] wv, input logic [7:0] dat, output logic [7:0] got);
    REQ = '{valid: 1'b1, op: k, wr: w, acc_b: a, file: ad[7:0], bank: ad[11:8], wreg: wv, wdata: dat};
    @(posedge REF_CLK);
    #1;
    REQ.valid = 1'b0;
    got = 8'h00;
    for (int n = 0; n < 6 && (w || RVALID !== 1'b1); n++) begin
      @(posedge REF_CLK);
      #1;
    end
    if (!w) begin
      if (RVALID === 1'b1) got = RDATA;
      else chk(16'h0, 16'h1);
    end
  endtask
  task automatic rdx(input logic [11:0] ad, input logic [7:0] wv);
    op(DMAG_OP_DIRECT, 1'b0, 1'b1, ad, wv, 8'h00, rd);
  endtask
  task automatic wrx(input logic [11:0] ad, input logic [7:0] d);
    op(DMAG_OP_DIRECT, 1'b1, 1'b1, ad, 8'h00, d, rd);
  endtask
  // Pointer loaded by direct writes of its low then high byte
  task automatic setp(input logic [11:0] lo, input logic [11:0] v);
    wrx(lo, v[7:0]);
    wrx(lo + 12'h001, {4'h0, v[11:8]});
  endtask
  task automatic t_reset();
    chk(PTR0, 12'h000);
    chk(PTR1, 12'h000);
    chk(PTR2, 12'h000);
    chk({MEM.rd, MEM.wr, RVALID}, 16'h0);
  endtask
  task automatic t_direct();
    setp(12'hfe9, 12'h1ff);
    chk(PTR0, 12'h1ff);
    rdx(12'hfe9, 8'h00);
    chk(rd, 8'hff);
    rdx(12'hfea, 8'h00);
    chk(rd, 8'h01);
  endtask
  // Steps across the low byte boundary in both directions
  task automatic t_step();
    rdx(12'hfee, 8'h00);
    chk(rd, pat(12'h1ff));
    chk(PTR0, 12'h200);
    rdx(12'hfed, 8'h00);
    chk(rd, pat(12'h200));
    chk(PTR0, 12'h1ff);
    rdx(12'hfec, 8'h00);
    chk(PTR0, 12'h200);
    chk(rd, pat(12'h200));
  endtask
  task automatic t_pointer_plus_working_access();
    setp(12'hfe1, 12'hffe);
    rdx(12'hfe3, 8'h05);
    chk(rd, pat(12'h003));
    chk(PTR1, 12'hffe);
    setp(12'hfe1, 12'hf80);
    wrx(12'hfe7, 8'ha5);
    rdx(12'hfe7, 8'h00);
    chk(rd, 8'ha5);
    rdx(12'hf80, 8'h00);
    chk(rd, 8'ha5);
  endtask
  // Pointer aimed at another pair's plain port
  task automatic t_refuse();
    setp(12'hfe9, 12'hfe7);
    n0 = wr_count;
    rdx(12'hfef, 8'h00);
    chk(rd, 8'h00);
    wrx(12'hfef, 8'h77);
    chk(wr_count, n0);
    chk(PTR1, 12'hf80);
    rdx(12'hfe7, 8'h00);
    chk(rd, 8'ha5);
  endtask
  // Third pair aimed at its own low byte, written through plain and decrementing ports
  task automatic t_own();
    setp(12'hfd9, 12'hfd9);
    wrx(12'hfdf, 8'h44);
    chk(PTR2, 12'hf44);
    setp(12'hfd9, 12'hfd9);
    wrx(12'hfdd, 8'h55);
    chk(PTR2, 12'hf55);
  endtask
  // Access-bank operands with the bank field deliberately set to a stray value
  task automatic t_lit();
    setp(12'hfd9, 12'h100);
    op(DMAG_OP_DIRECT, 1'b0, 1'b0, 12'h510, 8'h00, 8'h00, rd);
    chk(rd, pat(12'h010));
    EXT_SET_EN = 1'b1;
    repeat (8) @(posedge REF_CLK);
    #1;
    op(DMAG_OP_DIRECT, 1'b0, 1'b0, 12'h510, 8'h00, 8'h00, rd);
    chk(rd, pat(12'h110));
    op(DMAG_OP_DIRECT, 1'b0, 1'b0, 12'h55f, 8'h00, 8'h00, rd);
    chk(rd, pat(12'h15f));
    op(DMAG_OP_DIRECT, 1'b0, 1'b0, 12'h560, 8'h00, 8'h00, rd);
    chk(rd, pat(12'h060));
    op(DMAG_OP_DIRECT, 1'b0, 1'b0, 12'h590, 8'h00, 8'h00, rd);
    chk(rd, pat(12'hf90));
    rdx(12'h310, 8'h00);
    chk(rd, pat(12'h310));
    // First pair still aims at a virtual port from the refusal test; give it a plain target
    setp(12'hfe9, 12'h200);
    rdx(12'hfef, 8'h00);
    chk(rd, pat(12'h200));
    setp(12'hfd9, 12'hff0);
    op(DMAG_OP_DIRECT, 1'b0, 1'b0, 12'h05f, 8'h00, 8'h00, rd);
    chk(rd, pat(12'h04f));
    n0 = wr_count;
    op(DMAG_OP_LITERAL, 1'b1, 1'b0, 12'h010, 8'h00, 8'h3c, rd);
    chk(wr_count, n0);
    chk(PTR2, 12'hff0);
  endtask
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // 200 MHz core clock
  initial begin
    REF_CLK = 1'b0;
    forever #2.5 REF_CLK = ~REF_CLK;
  end
  // Main sequence after a 16-cycle reset
  initial begin
    RST_B = 1'b0;
    EXT_SET_EN = 1'b0;
    REQ = '0;
    bad_count = 0;
    checks = 0;
    repeat (16) @(posedge REF_CLK);
    #1;
    RST_B = 1'b1;
    t_reset();
    t_direct();
    t_step();
    t_pointer_plus_working_access();
    t_refuse();
    t_own();
    t_lit();
    close_out();
  end
  // Whole run needs well under a thousand cycles
  initial begin
    #50000;
    bad_count++;
    $display("ERROR at %0t: watchdog expired", $time);
    close_out();
  end
endmodule // tb
